//--- common/fca_pkg.sv
// Notes on behaviour
// - Down-slope: average off-time samples after blanking.
// - Up-slope: average on-time samples after blanking.
// - Low average sets undercurrent status, same response.
// - Out-of-span threshold writes are refused, value kept.
// - Threshold is signed linear-11 word, amperes.
// - Threshold starts at minus 0.8 times strap limit.
// - Config byte resets 01h, bits 7:3 reserved.
// - Config bit 2 turns gate bias regulator off.
// - Config bit 1 picks 1.8 V bus thresholds.
// - Config bit 0 picks lower PWM mid-drive level.
// - Live capture record refreshed every cycle.
// - Any fault copies live record into flash.
// - Capture read returns exactly thirty-two bytes.
// - Bytes 31:22 hold duty, frequency, three temperatures.
// - Bytes 21:16 hold six status byte copies.
// - Bytes 15:8 hold peak, current, voltages.
// - Bytes 7:0 all-faults, first-fault, uptime, flash status.
// - First-fault byte: bits 3..0 peak/avg OC, OV, UV.
// - All-faults bits 15..8 as listed.
// - All-faults bits 7..0 as listed.
// - Undercurrent pulls alert low until faults cleared.
package fca_pkg;
	// Command codes of the register group
	localparam logic [7:0] CMD_AVG_UC_THR = 8'hE8;
	localparam logic [7:0] CMD_ADV_CFG = 8'hE9;
	localparam logic [7:0] CMD_CAPTURE = 8'hEA;
	// Lengths in bytes
	localparam logic [5:0] LEN_AVG_UC_THR = 6'h02;
	localparam logic [5:0] LEN_ADV_CFG = 6'h01;
	localparam logic [5:0] LEN_CAPTURE = 6'h20;
	// Configuration byte layout and reset
	localparam logic [2:0] ADV_CFG_RESET = 3'h1;
	localparam int ADV_GATE_BIAS_OFF_BIT = 2;
	localparam int ADV_BUS_THR_BIT = 1;
	localparam int ADV_MIDDRIVE_BIT = 0;
	// Linear-11 layout
	localparam int LIN_EXP_MSB = 15;
	localparam int LIN_EXP_LSB = 11;
	localparam int LIN_MAN_MSB = 10;
	// Current fixed point: 1/16 A per count
	localparam int FIX_FRAC = 4;
	localparam logic signed [31:0] THR_MIN_FIX = -32'sd1600; // -100 A
	localparam logic signed [31:0] THR_MAX_FIX = 32'sd0; // 0 A
	// All-faults bit positions
	localparam int AF_PEAK_OC = 10;
	localparam int AF_OUTPUT_OVERVOLTAGE_FLAG = 6;
	localparam int AF_INPUT_UNDERVOLTAGE_FLAG = 2;
	localparam int AF_AVG_OC = 1;
	localparam int AF_AVG_UC = 0;
	// First-fault bit positions
	localparam int FF_PEAK_OC = 3;
	localparam int FF_AVG_OC = 2;
	localparam int FF_OUTPUT_OVERVOLTAGE_FLAG = 1;
	localparam int FF_INPUT_UNDERVOLTAGE_FLAG = 0;
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int CS_BLANK_NS = 40;
	localparam int BLANK_CYC = (CS_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [4:0] byte_idx;
		logic [15:0] wdata;
	} fca_req_type;

	typedef struct packed {
		logic valid;
		logic err;
		logic [5:0] len;
		logic [15:0] data;
	} fca_rsp_type;

	typedef struct packed {
		logic [15:0] duty;
		logic [15:0] freq;
		logic [15:0] temp_ext2;
		logic [15:0] temp_ext1;
		logic [15:0] temp_int;
		logic [7:0] st_mfr;
		logic [7:0] st_cml;
		logic [7:0] st_temp;
		logic [7:0] st_input;
		logic [7:0] st_iout;
		logic [7:0] st_vout;
		logic [15:0] iout_peak;
		logic [15:0] iout;
		logic [15:0] vout;
		logic [15:0] vin;
		logic [7:0] flash_status;
	} fca_telem_type;
endpackage

//--- verilog/fca_top.sv
`timescale 1ns/10ps
`default_nettype none
module fca_top #(
	parameter int SAMPLE_W = 16,
	parameter int CNT_W = 12
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire fca_pkg::fca_req_type req,
	output fca_pkg::fca_rsp_type rsp,
	input wire logic [15:0] strap_oc_limit,
	input wire logic sense_up_slope,
	input wire logic pwm_on,
	input wire logic sample_valid,
	input wire logic signed [SAMPLE_W-1:0] sample,
	input wire logic inst_uc_event,
	input wire logic [15:0] fault_events,
	input wire logic clear_faults,
	input wire logic read_flash_copy,
	input wire logic uptime_tick,
	input wire fca_pkg::fca_telem_type telem,
	output logic uc_fault_response,
	output logic alert_line_output_n,
	output logic flash_commit,
	output logic gate_bias_regulator_off,
	output logic bus_threshold_select,
	output logic pwm_middrive_level_select
);
	import fca_pkg::*;

	// Elaboration check: wider samples or counts would overflow the 48-bit product
	if (SAMPLE_W < 8 || SAMPLE_W > 24 || CNT_W < 4 || CNT_W > 16) begin
		$error("fca_top: unsupported SAMPLE_W or CNT_W");
	end

	// Linear-11 word to signed fixed point, 1/16 A per count
	function automatic logic signed [31:0] lin11_to_fix(input logic [15:0] w);
		logic signed [4:0] n;
		logic signed [31:0] v;
		n = signed'(w[LIN_EXP_MSB:LIN_EXP_LSB]);
		v = 32'(signed'(w[LIN_MAN_MSB:0])) <<< FIX_FRAC;
		if (n >= 0) begin
			v = v <<< n;
		end else begin
			v = v >>> (-n);
		end
		return v;
	endfunction

	// Default threshold: mantissa scaled by -4/5, same exponent
	function automatic logic [15:0] default_thr(input logic [15:0] oc);
		logic signed [15:0] y;
		logic signed [15:0] m;
		y = 16'(signed'(oc[LIN_MAN_MSB:0]));
		m = -((y * 16'sd4) / 16'sd5);
		return {oc[LIN_EXP_MSB:LIN_EXP_LSB], m[LIN_MAN_MSB:0]};
	endfunction

	// Live record assembly, byte 0 in the low bits
	function automatic logic [255:0] build_record(input fca_telem_type t, input logic [15:0] af,
		input logic [7:0] ff, input logic [31:0] up);
		return {t.duty, t.freq, t.temp_ext2, t.temp_ext1, t.temp_int,
			t.st_mfr, t.st_cml, t.st_temp, t.st_input, t.st_iout, t.st_vout,
			t.iout_peak, t.iout, t.vout, t.vin,
			af, ff, up, t.flash_status};
	endfunction

	logic [15:0] thr_word_ff;
	logic signed [31:0] thr_fix_ff;
	logic init_done_ff;
	logic [2:0] adv_cfg_ff;
	logic in_interval;
	logic in_interval_ff;
	logic [CNT_W-1:0] blank_cnt_ff;
	logic [CNT_W-1:0] nsamp_ff;
	logic signed [SAMPLE_W+CNT_W-1:0] sum_ff;
	logic signed [47:0] avg_scaled;
	logic avg_uc_event;
	logic uc_event;
	logic uc_status_ff;
	logic [15:0] all_faults_ff;
	logic [15:0] nxt_all_faults;
	logic [7:0] first_fault_ff;
	logic [7:0] nxt_first_fault;
	logic first_taken_ff;
	logic [31:0] uptime_ff;
	logic [255:0] live_rec_ff;
	logic [255:0] flash_rec_ff;
	logic [255:0] rd_rec;
	logic signed [31:0] wr_fix;
	logic wr_thr_ok;
	logic wr_positive;

	// Averaging window: on-time for up-slope, off-time for down-slope
	assign in_interval = sense_up_slope ? pwm_on : ~pwm_on;

	// Blanking counter restarts at each window start, sums samples past it
	// The entry edge and the BLANK_CYC edges after it drop their samples
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_interval_ff <= 1'b0;
			blank_cnt_ff <= '0;
			nsamp_ff <= '0;
			sum_ff <= '0;
		end else begin
			in_interval_ff <= in_interval;
			if (in_interval && !in_interval_ff) begin
				blank_cnt_ff <= '0;
				nsamp_ff <= '0;
				sum_ff <= '0;
			end else if (in_interval) begin
				if (blank_cnt_ff < CNT_W'(BLANK_CYC)) begin
					blank_cnt_ff <= blank_cnt_ff + 1'b1;
				end else if (sample_valid && nsamp_ff != '1) begin
					nsamp_ff <= nsamp_ff + 1'b1;
					sum_ff <= sum_ff + (SAMPLE_W+CNT_W)'(sample);
				end
			end
		end
	end

	// Average below threshold: sum < threshold * count, no divider needed
	assign avg_scaled = 48'(thr_fix_ff) * $signed({1'b0, nsamp_ff});
	assign avg_uc_event = in_interval_ff && !in_interval && nsamp_ff != '0 &&
		48'(sum_ff) < avg_scaled;

	assign uc_event = avg_uc_event | inst_uc_event;

	// Write decode of threshold value and span check
	assign wr_fix = lin11_to_fix(req.wdata);
	// Any positive mantissa lies above 0 A, even one that rounds to zero counts
	assign wr_positive = !req.wdata[LIN_MAN_MSB] && req.wdata[LIN_MAN_MSB-1:0] != '0;
	assign wr_thr_ok = !wr_positive && wr_fix >= THR_MIN_FIX && wr_fix <= THR_MAX_FIX;

	// Threshold register, loaded from strap once after reset release
	// A write on that load edge is dropped, so hosts start one edge later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			thr_word_ff <= 16'h0000;
			thr_fix_ff <= '0;
			init_done_ff <= 1'b0;
		end else if (!init_done_ff) begin
			init_done_ff <= 1'b1;
			thr_word_ff <= default_thr(strap_oc_limit);
			thr_fix_ff <= lin11_to_fix(default_thr(strap_oc_limit));
		end else if (req.valid && req.write && req.code == CMD_AVG_UC_THR && wr_thr_ok) begin
			thr_word_ff <= req.wdata;
			thr_fix_ff <= wr_fix;
		end
	end

	// Configuration byte and its control outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adv_cfg_ff <= ADV_CFG_RESET;
		end else if (req.valid && req.write && req.code == CMD_ADV_CFG) begin
			adv_cfg_ff <= req.wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gate_bias_regulator_off <= ADV_CFG_RESET[ADV_GATE_BIAS_OFF_BIT];
			bus_threshold_select <= ADV_CFG_RESET[ADV_BUS_THR_BIT];
			pwm_middrive_level_select <= ADV_CFG_RESET[ADV_MIDDRIVE_BIT];
		end else begin
			gate_bias_regulator_off <= adv_cfg_ff[ADV_GATE_BIAS_OFF_BIT];
			bus_threshold_select <= adv_cfg_ff[ADV_BUS_THR_BIT];
			pwm_middrive_level_select <= adv_cfg_ff[ADV_MIDDRIVE_BIT];
		end
	end

	// Undercurrent status: set wins over clear, alert low while set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uc_status_ff <= 1'b0;
			alert_line_output_n <= 1'b1;
			uc_fault_response <= 1'b0;
		end else begin
			if (uc_event) begin
				uc_status_ff <= 1'b1;
			end else if (clear_faults) begin
				uc_status_ff <= 1'b0;
			end
			alert_line_output_n <= ~(uc_event | (uc_status_ff & ~clear_faults));
			uc_fault_response <= uc_event;
		end
	end

	// Fault bitfields: all faults accumulate, first fault latches once
	always_comb begin
		nxt_all_faults = all_faults_ff | fault_events;
		nxt_all_faults[AF_AVG_UC] = nxt_all_faults[AF_AVG_UC] | avg_uc_event;
		nxt_first_fault = first_fault_ff;
		if (!first_taken_ff) begin
			if (fault_events[AF_PEAK_OC]) begin
				nxt_first_fault = 8'h01 << FF_PEAK_OC;
			end else if (fault_events[AF_AVG_OC]) begin
				nxt_first_fault = 8'h01 << FF_AVG_OC;
			end else if (fault_events[AF_OUTPUT_OVERVOLTAGE_FLAG]) begin
				nxt_first_fault = 8'h01 << FF_OUTPUT_OVERVOLTAGE_FLAG;
			end else if (fault_events[AF_INPUT_UNDERVOLTAGE_FLAG]) begin
				nxt_first_fault = 8'h01 << FF_INPUT_UNDERVOLTAGE_FLAG;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			all_faults_ff <= 16'h0000;
			first_fault_ff <= 8'h00;
			first_taken_ff <= 1'b0;
		end else if (clear_faults && fault_events == 16'h0000 && !avg_uc_event) begin
			all_faults_ff <= 16'h0000;
			first_fault_ff <= 8'h00;
			first_taken_ff <= 1'b0;
		end else begin
			all_faults_ff <= nxt_all_faults;
			first_fault_ff <= nxt_first_fault;
			if (nxt_first_fault != 8'h00) begin
				first_taken_ff <= 1'b1;
			end
		end
	end

	// Uptime counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uptime_ff <= 32'h00000000;
		end else if (uptime_tick) begin
			uptime_ff <= uptime_ff + 32'h00000001;
		end
	end

	// Live record refreshed every cycle; flash copy taken on any fault
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			live_rec_ff <= '0;
			flash_rec_ff <= '0;
			flash_commit <= 1'b0;
		end else begin
			live_rec_ff <= build_record(telem, all_faults_ff, first_fault_ff, uptime_ff);
			flash_commit <= (fault_events != 16'h0000) | uc_event;
			if ((fault_events != 16'h0000) | uc_event) begin
				flash_rec_ff <= live_rec_ff;
			end
		end
	end

	// Host picks the stored copy via capture control before reading
	assign rd_rec = read_flash_copy ? flash_rec_ff : live_rec_ff;

	// Command answers, one cycle after the request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.err <= 1'b0;
			rsp.len <= 6'h00;
			rsp.data <= 16'h0000;
			if (req.valid) begin
				unique case (req.code)
					CMD_AVG_UC_THR: begin
						rsp.len <= LEN_AVG_UC_THR;
						rsp.data <= thr_word_ff;
						rsp.err <= req.write && !wr_thr_ok;
					end
					CMD_ADV_CFG: begin
						rsp.len <= LEN_ADV_CFG;
						rsp.data <= {13'h0000, adv_cfg_ff};
					end
					CMD_CAPTURE: begin
						rsp.len <= LEN_CAPTURE;
						rsp.data <= {8'h00, rd_rec[{req.byte_idx, 3'h0} +: 8]};
						rsp.err <= req.write;
					end
					default: begin
						rsp.err <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/fca_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fca_top_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire fca_pkg::fca_req_type req,
	input wire fca_pkg::fca_rsp_type rsp,
	input wire logic inst_uc_event,
	input wire logic [15:0] fault_events,
	input wire logic clear_faults,
	input wire logic uc_fault_response,
	input wire logic alert_line_output_n,
	input wire logic flash_commit,
	input wire logic gate_bias_regulator_off,
	input wire logic bus_threshold_select,
	input wire logic pwm_middrive_level_select
);
	import fca_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Request shapes
	sequence s_cfg_wr;
		req.valid && req.write && req.code == CMD_ADV_CFG;
	endsequence
	sequence s_thr_pos;
		req.valid && req.write && req.code == CMD_AVG_UC_THR && !req.wdata[10] && req.wdata[9:0] != 10'h000;
	endsequence
	property p_cfg_out;
		s_cfg_wr |-> ##2 {gate_bias_regulator_off, bus_threshold_select, pwm_middrive_level_select} == $past(req.wdata[2:0], 2);
	endproperty
	a_cfg_out: assert property (p_cfg_out)
		else $error("config pins differ from written bits");
	property p_cap_len;
		rsp.valid && $past(req.code == CMD_CAPTURE && !req.write) |-> rsp.len == LEN_CAPTURE && !rsp.err;
	endproperty
	a_cap_len: assert property (p_cap_len)
		else $error("capture read length wrong");
	property p_cap_wr;
		req.valid && req.write && req.code == CMD_CAPTURE |=> rsp.valid && rsp.err;
	endproperty
	a_cap_wr: assert property (p_cap_wr)
		else $error("capture write not refused");
	property p_thr_ref;
		s_thr_pos |=> rsp.valid && rsp.err;
	endproperty
	a_thr_ref: assert property (p_thr_ref)
		else $error("positive threshold accepted");
	property p_uc_resp;
		uc_fault_response |-> !alert_line_output_n && flash_commit;
	endproperty
	a_uc_resp: assert property (p_uc_resp)
		else $error("fault response without alert or commit");
	property p_inst_uc;
		inst_uc_event |=> uc_fault_response;
	endproperty
	a_inst_uc: assert property (p_inst_uc)
		else $error("instant undercurrent not answered");
	property p_alert_hold;
		!alert_line_output_n && !clear_faults |=> !alert_line_output_n;
	endproperty
	a_alert_hold: assert property (p_alert_hold)
		else $error("alert released without clear");
	property p_alert_fall;
		$fell(alert_line_output_n) |-> uc_fault_response;
	endproperty
	a_alert_fall: assert property (p_alert_fall)
		else $error("alert fell without fault");
	property p_fault_commit;
		fault_events != 16'h0000 |=> flash_commit;
	endproperty
	a_fault_commit: assert property (p_fault_commit)
		else $error("fault without flash commit");
endmodule
bind fca_top fca_top_chk chk_u (.clk, .arst_n, .req, .rsp, .inst_uc_event, .fault_events, .clear_faults, .uc_fault_response,
	.alert_line_output_n, .flash_commit, .gate_bias_regulator_off, .bus_threshold_select, .pwm_middrive_level_select);
`default_nettype wire

//--- bench/fca_host.sv
`timescale 1ns/10ps
`default_nettype none
module fca_host (
	input wire logic clk,
	output fca_pkg::fca_req_type req,
	output logic read_flash_copy,
	input wire fca_pkg::fca_rsp_type rsp
);
	import fca_pkg::*;
	// Idle bus from time zero
	initial begin
		req = '0;
		read_flash_copy = 1'b0;
	end
	// One request; the answer is taken in the cycle after acceptance
	task automatic xfer(input logic w, input logic [7:0] c, input logic [4:0] i, input logic [15:0] d,
		output fca_rsp_type r);
		@(posedge clk);
		req <= '{valid: 1'b1, write: w, code: c, byte_idx: i, wdata: d};
		@(posedge clk);
		req <= '0;
		#1;
		r = rsp;
	endtask
	// Selects the committed copy before record reads
	task automatic flash_sel(input logic b);
		@(posedge clk);
		read_flash_copy <= b;
	endtask
endmodule
`default_nettype wire

//--- bench/test_fault_capture_and_avg_uc_config.sv
`timescale 1ns/10ps
`default_nettype none
module test_fault_capture_and_avg_uc_config;
	import fca_pkg::*;
	logic clk, arst_n, sense_up_slope, pwm_on, sample_valid, inst_uc_event, clear_faults, uptime_tick;
	logic read_flash_copy, uc_fault_response, alert_line_output_n, flash_commit;
	logic gate_bias_regulator_off, bus_threshold_select, pwm_middrive_level_select;
	logic signed [15:0] sample;
	logic [15:0] strap_oc_limit, fault_events;
	logic [199:0] ta;
	fca_req_type req;
	fca_rsp_type rsp, r;
	fca_telem_type telem;
	int n_mismatch, check_count, cyc, hits;
	fca_top dut_u (.clk, .arst_n, .req, .rsp, .strap_oc_limit, .sense_up_slope, .pwm_on, .sample_valid, .sample,
		.inst_uc_event, .fault_events, .clear_faults, .read_flash_copy, .uptime_tick, .telem, .uc_fault_response,
		.alert_line_output_n, .flash_commit, .gate_bias_regulator_off, .bus_threshold_select, .pwm_middrive_level_select);
	fca_host host_u (.clk, .req, .read_flash_copy, .rsp);
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 6000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read with compare; byte answers sit in the low eight bits
	task automatic rc(input string what, input logic [7:0] c, input logic [4:0] i, input logic [15:0] e);
		logic [15:0] m;
		m = c == CMD_AVG_UC_THR ? 16'hFFFF : 16'h00FF;
		host_u.xfer(1'b0, c, i, 16'h0000, r);
		chk(what, e, r.data & m);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
		host_u.xfer(1'b1, c, 5'h00, d, r);
		chk("write err", 16'(e), 16'(r.err));
	endtask
	// One averaging window, 12 early samples then 18 late ones
	task automatic win(input logic lvl, input logic signed [15:0] bv, input logic signed [15:0] pv);
		hits = 0;
		@(posedge clk);
		pwm_on <= lvl;
		for (int k = 0; k < 30; k++) begin
			sample_valid <= 1'b1;
			sample <= k < 12 ? bv : pv;
			@(posedge clk);
		end
		sample_valid <= 1'b0;
		pwm_on <= ~lvl;
		repeat (4) begin
			@(posedge clk);
			#1;
			hits += (uc_fault_response === 1'b1);
		end
	endtask
	initial begin
		{arst_n, sense_up_slope, pwm_on, sample_valid, inst_uc_event, clear_faults, uptime_tick} = 7'h20;
		strap_oc_limit = 16'h0064;
		sample = '0;
		fault_events = '0;
		n_mismatch = 0;
		check_count = 0;
		cyc = 0;
		for (int k = 0; k < 25; k++)
			ta[k*8+:8] = 8'h30 + 8'(k);
		telem = fca_telem_type'(ta);
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		uptime_tick <= 1'b1;
		repeat (3) @(posedge clk);
		uptime_tick <= 1'b0;
		rc("cfg reset", CMD_ADV_CFG, 5'h00, 16'h0001);
		chk("cfg pins", 16'h0001, 16'({gate_bias_regulator_off, bus_threshold_select, pwm_middrive_level_select}));
		rc("thr default", CMD_AVG_UC_THR, 5'h00, 16'h07B0);
		rc("uptime", CMD_CAPTURE, 5'h01, 16'h0003);
		$display("test reset done");
		wr(CMD_AVG_UC_THR, 16'h07CE, 1'b0);
		wr(CMD_AVG_UC_THR, 16'h000A, 1'b1);
		wr(CMD_AVG_UC_THR, 16'h0738, 1'b1);
		rc("thr kept", CMD_AVG_UC_THR, 5'h00, 16'h07CE);
		wr(CMD_AVG_UC_THR, 16'h0FE7, 1'b0);
		wr(CMD_ADV_CFG, 16'h00FE, 1'b0);
		@(posedge clk);
		#1;
		chk("cfg pins", 16'h0006, 16'({gate_bias_regulator_off, bus_threshold_select, pwm_middrive_level_select}));
		rc("cfg read", CMD_ADV_CFG, 5'h00, 16'h0006);
		$display("test registers done");
		win(1'b1, -16'sd3000, 16'sd0);
		chk("uc up", 16'h0000, 16'(hits));
		@(posedge clk);
		sense_up_slope <= 1'b0;
		pwm_on <= 1'b1;
		win(1'b0, 16'sd2000, -16'sd2000);
		chk("uc down", 16'h0001, 16'(hits));
		chk("alert", 16'h0000, 16'(alert_line_output_n));
		rc("faults low", CMD_CAPTURE, 5'h06, 16'h0001);
		@(posedge clk);
		clear_faults <= 1'b1;
		@(posedge clk);
		clear_faults <= 1'b0;
		@(posedge clk);
		#1;
		chk("alert clr", 16'h0001, 16'(alert_line_output_n));
		$display("test undercurrent done");
		@(posedge clk);
		fault_events <= 16'h0001 << AF_OUTPUT_OVERVOLTAGE_FLAG;
		@(posedge clk);
		fault_events <= 16'h0001 << AF_PEAK_OC;
		@(posedge clk);
		fault_events <= '0;
		rc("first", CMD_CAPTURE, 5'h05, 16'h0002);
		rc("faults hi", CMD_CAPTURE, 5'h07, 16'h0004);
		rc("faults lo", CMD_CAPTURE, 5'h06, 16'h0040);
		for (int i = 8; i < 32; i++)
			rc("live", CMD_CAPTURE, 5'(i), {8'h00, ta[(i-7)*8+:8]});
		rc("flash st", CMD_CAPTURE, 5'h00, {8'h00, ta[7:0]});
		@(posedge clk);
		telem <= fca_telem_type'(~ta);
		rc("live new", CMD_CAPTURE, 5'h08, {8'h00, ~ta[15:8]});
		host_u.flash_sel(1'b1);
		rc("flash", CMD_CAPTURE, 5'h08, {8'h00, ta[15:8]});
		host_u.flash_sel(1'b0);
		$display("test record done");
		wr(CMD_CAPTURE, 16'h0000, 1'b1);
		@(posedge clk);
		inst_uc_event <= 1'b1;
		@(posedge clk);
		inst_uc_event <= 1'b0;
		#1;
		chk("inst uc", 16'h0001, 16'(uc_fault_response));
		$display("test refusals done");
		conclude();
	end
endmodule
`default_nettype wire
